// [src/apmc_power_mode_control.sv]
// Power-mode control and serial result output of a sampling converter.
`timescale 1ns/1ps

module apmc_power_mode_control
#(
  parameter int unsigned RES_BITS      = 12,
  parameter bit          RESET_IN_DOWN = 1'b0
)
(
  // Clock, reset and enable.
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_clk_en,
  // Serial pins from the host.
  input  wire logic                  i_cs_b,
  input  wire logic                  i_sclk,
  // Result from the converter core.
  input  wire logic [RES_BITS-1:0]   i_sample_data,
  // Serial data pin as output and enable.
  output logic                       o_serial_out_line,
  output logic                       o_serial_out_line_oe,
  // Analog status.
  output logic                       o_analog_on,
  output logic                       o_track,
  output logic                       o_sample_strobe,
  output logic                       o_power_down,
  output logic                       o_dummy_frame
);
  import apmc_pkg::*;

  localparam int unsigned PAD_BITS = APMC_FIELD_W - RES_BITS;

  // The output word only has room for a 12-bit field, and only three resolutions exist.
  if (RES_BITS != 12 && RES_BITS != 10 && RES_BITS != 8)
  begin : g_bad_res
    $error("RES_BITS must be 8, 10 or 12");
  end

  apmc_pin_if pins ();

  apmc_frame_type             frame_reg;
  apmc_mode_type              mode_reg;
  logic [APMC_CNT_W-1:0]      cnt_reg;
  logic [APMC_WORD_W-1:0]     shift_reg;
  logic                       oe_reg;
  logic                       track_reg;
  logic                       analog_reg;
  logic                       wake_reg;
  logic                       wake_edge_seen_reg;
  logic                       strobe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  apmc_pin_sync u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_pins    ({i_sclk, i_cs_b}),
    .pins      (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Window decode, used by several processes below.
  function automatic logic in_down_window(input logic [APMC_CNT_W-1:0] cnt);
    in_down_window = (cnt >= APMC_CNT_GLITCH) && (cnt < APMC_CNT_KEEP);
  endfunction

  function automatic logic [APMC_WORD_W-1:0] build_word(input logic [RES_BITS-1:0] data);
    logic [APMC_FIELD_W-1:0] field;
    field = APMC_FIELD_W'(data) << PAD_BITS;
    build_word = {{APMC_LEAD_ZEROS{1'b0}}, field};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame state: a frame opens on chip-select fall and closes on its rise.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      frame_reg <= APMC_IDLE;
    else if (i_clk_en)
    begin
      case (frame_reg)
        APMC_IDLE:
          if (pins.cs_fall)
            frame_reg <= APMC_ACTIVE;
        APMC_ACTIVE:
          if (pins.cs_rise)
            frame_reg <= APMC_IDLE;
          else if (pins.sclk_fall && cnt_reg == APMC_CNT_FRAME - 5'h01)
            frame_reg <= APMC_DONE;
        APMC_DONE:
          if (pins.cs_rise)
            frame_reg <= APMC_IDLE;
        default:
          frame_reg <= APMC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling-edge counter; it saturates so a long low period cannot wrap into a window.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_reg <= '0;
    else if (i_clk_en)
    begin
      if (pins.cs_fall)
        cnt_reg <= '0;
      else if (frame_reg != APMC_IDLE && pins.sclk_fall && cnt_reg < APMC_CNT_FRAME)
        cnt_reg <= cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decision at chip-select rise, from the count seen at that moment.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      mode_reg <= RESET_IN_DOWN ? APMC_MODE_DOWN : APMC_MODE_NORMAL;
    else if (i_clk_en && pins.cs_rise && frame_reg != APMC_IDLE)
    begin
      if (wake_reg)
        mode_reg <= (cnt_reg < APMC_CNT_KEEP) ? APMC_MODE_DOWN : APMC_MODE_NORMAL;
      else if (in_down_window(cnt_reg))
        mode_reg <= APMC_MODE_DOWN;
      else
        mode_reg <= APMC_MODE_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake tracking: a frame that starts in power-down is a dummy cycle.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      wake_reg <= 1'b0;
    else if (i_clk_en)
    begin
      if (pins.cs_fall)
        wake_reg <= (mode_reg == APMC_MODE_DOWN);
      else if (pins.cs_rise)
        wake_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog supply: on at a wake fall, off on entry to power-down.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      analog_reg <= !RESET_IN_DOWN;
    else if (i_clk_en)
    begin
      if (pins.cs_fall)
        analog_reg <= 1'b1;
      else if (pins.cs_rise && frame_reg != APMC_IDLE)
      begin
        if (wake_reg ? (cnt_reg < APMC_CNT_KEEP) : in_down_window(cnt_reg))
          analog_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Track-and-hold. A wake frame waits for the first clock edge of either sense
  // before tracking, because the hold was kept through power-down. The return to
  // track at chip-select rise repeats the power-down decision, because the analog
  // flag still reads on in that very cycle and would otherwise release the hold.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      track_reg          <= APMC_RST_TRACK;
      wake_edge_seen_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (pins.cs_fall)
      begin
        track_reg          <= 1'b0;
        wake_edge_seen_reg <= 1'b0;
      end
      else if (wake_reg && !wake_edge_seen_reg && (pins.sclk_fall || pins.sclk_rise))
      begin
        track_reg          <= 1'b1;
        wake_edge_seen_reg <= 1'b1;
      end
      else if (!wake_reg && frame_reg != APMC_IDLE && pins.sclk_rise && cnt_reg >= APMC_CNT_TRACK)
        track_reg <= 1'b1;
      else if (pins.cs_rise && analog_reg && !(wake_reg ? (cnt_reg < APMC_CNT_KEEP) : in_down_window(cnt_reg)))
        track_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter and enable; the first bit is presented at the fall itself.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shift_reg <= '0;
      oe_reg    <= APMC_RST_OE;
    end
    else if (i_clk_en)
    begin
      if (pins.cs_fall)
      begin
        shift_reg <= build_word(i_sample_data);
        oe_reg    <= 1'b1;
      end
      else if (pins.cs_rise)
        oe_reg <= 1'b0;
      else if (frame_reg == APMC_ACTIVE && pins.sclk_fall)
      begin
        shift_reg <= {shift_reg[APMC_WORD_W-2:0], 1'b0};
        if (cnt_reg == APMC_CNT_FRAME - 5'h01)
          oe_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample strobe to the converter core, one cycle per frame start.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      strobe_reg <= 1'b0;
    else if (i_clk_en)
      strobe_reg <= pins.cs_fall;
  end

  // Outputs.
  assign o_serial_out_line    = shift_reg[APMC_WORD_W-1];
  assign o_serial_out_line_oe = oe_reg;
  assign o_analog_on          = analog_reg;
  assign o_track              = track_reg;
  assign o_sample_strobe      = strobe_reg;
  assign o_power_down         = (mode_reg == APMC_MODE_DOWN);
  assign o_dummy_frame        = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_cnt_sat;
    @(posedge i_sys_clk) disable iff (!i_rst_b) cnt_reg <= APMC_CNT_FRAME;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("edge count above sixteen");

  property p_glitch;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      pins.cs_rise && frame_reg != APMC_IDLE && !wake_reg && cnt_reg < APMC_CNT_GLITCH
      |=> mode_reg == APMC_MODE_NORMAL && analog_reg;
  endproperty
  a_glitch: assert property (p_glitch) else $error("short frame changed mode");

  property p_pd_enter;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      pins.cs_rise && frame_reg != APMC_IDLE && !wake_reg && in_down_window(cnt_reg)
      |=> mode_reg == APMC_MODE_DOWN && !analog_reg && !oe_reg && !track_reg;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

  property p_abort;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      pins.cs_rise && !wake_reg && frame_reg == APMC_ACTIVE && cnt_reg >= APMC_CNT_KEEP
      |=> mode_reg == APMC_MODE_NORMAL && analog_reg && !oe_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("late abort handled wrongly");

  property p_frame_start;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      pins.cs_fall |=> oe_reg && !track_reg && strobe_reg && analog_reg ##1 !strobe_reg;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start effects missing");

  property p_oe_end;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(cnt_reg == APMC_CNT_FRAME) |-> !oe_reg && frame_reg == APMC_DONE;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output driven after sixteen edges");

  property p_wake_fail;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      pins.cs_rise && wake_reg && cnt_reg < APMC_CNT_KEEP |=> mode_reg == APMC_MODE_DOWN && !analog_reg;
  endproperty
  a_wake_fail: assert property (p_wake_fail) else $error("early rise did not return to power-down");

  property p_shift;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      frame_reg == APMC_ACTIVE && pins.sclk_fall && !pins.cs_rise
      |=> cnt_reg == $past(cnt_reg) + 5'h01 && shift_reg[APMC_WORD_W-1] == $past(shift_reg[APMC_WORD_W-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted on falling edge");

  property p_wake_track;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      wake_reg && !wake_edge_seen_reg && !pins.cs_fall && (pins.sclk_fall || pins.sclk_rise) |=> track_reg;
  endproperty
  a_wake_track: assert property (p_wake_track) else $error("no track after first wake edge");

  c_full_frame: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) frame_reg == APMC_DONE ##1 pins.cs_rise);
  c_enter_down: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(mode_reg == APMC_MODE_DOWN));
  c_wake_ok:    cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $fell(mode_reg == APMC_MODE_DOWN));
  c_wake_fail:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
                                pins.cs_rise && wake_reg && cnt_reg < APMC_CNT_KEEP);

endmodule

// [src/apmc_pkg.sv]
// Package with the constants and types shared by the power-mode control block.
package apmc_pkg;

  // Serial-clock falling-edge counts that mark the mode windows.
  localparam int unsigned APMC_CNT_W       = 5;
  localparam logic [4:0]  APMC_CNT_GLITCH  = 5'h02;
  localparam logic [4:0]  APMC_CNT_KEEP    = 5'h0a;
  localparam logic [4:0]  APMC_CNT_TRACK   = 5'h0d;
  localparam logic [4:0]  APMC_CNT_FRAME   = 5'h10;

  // Output word layout: leading zeros, then the result, then padding.
  localparam int unsigned APMC_WORD_W      = 16;
  localparam int unsigned APMC_LEAD_ZEROS  = 4;
  localparam int unsigned APMC_FIELD_W     = 12;

  // Pin indices inside the synchroniser array and their idle levels after reset.
  localparam int unsigned APMC_PIN_CS      = 0;
  localparam int unsigned APMC_PIN_SCLK    = 1;
  localparam int unsigned APMC_PIN_N       = 2;
  localparam logic [1:0]  APMC_PIN_RST     = 2'h1;

  // Values after reset.
  localparam logic        APMC_RST_TRACK   = 1'b1;
  localparam logic        APMC_RST_OE      = 1'b0;

  typedef enum logic {APMC_MODE_NORMAL, APMC_MODE_DOWN} apmc_mode_type;
  typedef enum logic [1:0] {APMC_IDLE, APMC_ACTIVE, APMC_DONE} apmc_frame_type;

endpackage

// [src/apmc_pin_if.sv]
// Interface that carries the synchronised pin levels and edge events to the core.
`timescale 1ns/1ps
interface apmc_pin_if;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  modport sync_side (output cs_low, output cs_fall, output cs_rise, output sclk_fall, output sclk_rise);
  modport core_side (input cs_low, input cs_fall, input cs_rise, input sclk_fall, input sclk_rise);
endinterface

// [src/apmc_pin_sync.sv]
// Two-stage synchronisers and edge detectors for the chip-select and serial-clock pins.
`timescale 1ns/1ps
module apmc_pin_sync
  import apmc_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_clk_en,
  // Raw pins: bit 0 chip-select (active low), bit 1 serial clock.
  input  wire logic [apmc_pkg::APMC_PIN_N-1:0] i_pins,
  // Events towards the core.
  apmc_pin_if.sync_side                      pins
);

  logic [APMC_PIN_N-1:0] meta_reg;
  logic [APMC_PIN_N-1:0] sync_reg;
  logic [APMC_PIN_N-1:0] prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser per pin; the first stage feeds only the second stage.
  genvar g;
  generate
    for (g = 0; g < APMC_PIN_N; g++)
    begin : g_pin
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          meta_reg[g] <= APMC_PIN_RST[g];
          sync_reg[g] <= APMC_PIN_RST[g];
          prev_reg[g] <= APMC_PIN_RST[g];
        end
        else if (i_clk_en)
        begin
          meta_reg[g] <= i_pins[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Edge events are one-cycle pulses, gated by the enable so a frozen block sees none.
  assign pins.cs_low    = ~sync_reg[APMC_PIN_CS];
  assign pins.cs_fall   = i_clk_en & prev_reg[APMC_PIN_CS] & ~sync_reg[APMC_PIN_CS];
  assign pins.cs_rise   = i_clk_en & ~prev_reg[APMC_PIN_CS] & sync_reg[APMC_PIN_CS];
  assign pins.sclk_fall = i_clk_en & prev_reg[APMC_PIN_SCLK] & ~sync_reg[APMC_PIN_SCLK];
  assign pins.sclk_rise = i_clk_en & ~prev_reg[APMC_PIN_SCLK] & sync_reg[APMC_PIN_SCLK];

endmodule

// [bench/apmc_host_model.sv]
// Serial host model that frames chip-select, toggles the serial clock and reads the result word.
`timescale 1ns/1ps
module apmc_host_model
(
  // Clock of the bench.
  input  wire logic i_sys_clk,
  // Pins towards the device.
  output logic      o_cs_b,
  output logic      o_sclk,
  // Pins and status from the device.
  input  wire logic i_serial_out_line,
  input  wire logic i_serial_out_line_oe,
  input  wire logic i_track,
  input  wire logic i_dummy_frame,
  input  wire logic i_analog_on,
  input  wire logic i_sample_strobe
);
  int   strobes;
  logic line_lvl;

  ////////////////////////////////////////////////////////////////////////////////
  // A released line reads as the inverse of the pad value, so a stale bit never passes.
  assign line_lvl = i_serial_out_line_oe ? i_serial_out_line : ~i_serial_out_line;

  // Both pins idle at their rest levels: chip-select high, serial clock low.
  initial
  begin
    o_cs_b  = 1'b1;
    o_sclk  = 1'b0;
    strobes = 0;
  end

  // Sample pulses are counted so the bench can see one per frame.
  always @(posedge i_sys_clk)
  begin
    if (i_sample_strobe === 1'b1)
      strobes <= strobes + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame with a given count of falling edges; serial clock 5 MHz, well under the limit.
  task automatic frame(input int falls, output logic [15:0] word, output logic [3:0] early,
                       output logic trk_first, output logic trk_end);
    word      = 16'h0000;
    trk_first = 1'bx;
    @(negedge i_sys_clk);
    o_cs_b = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    early = {i_serial_out_line_oe, i_track, i_dummy_frame, i_analog_on};
    for (int i = 0; i < falls; i++)
    begin
      o_sclk = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      if (i == 0)
        trk_first = i_track;
      word   = {word[14:0], line_lvl};
      o_sclk = 1'b0;
      repeat (4) @(negedge i_sys_clk);
    end
    trk_end = i_track;
    o_cs_b  = 1'b1;
    // The gap lets the line settle before any next frame starts.
    repeat (12) @(negedge i_sys_clk);
  endtask
endmodule

// [bench/tb.sv]
// Self-checking testbench for the power-mode control block.
`timescale 1ns/1ps
module tb;
  import apmc_pkg::*;
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        i_clk_en;
  logic [11:0] i_sample_data;
  logic        cs_b;
  logic        sclk;
  logic        sdo;
  logic        sdo_oe;
  logic        analog_on;
  logic        track;
  logic        strobe;
  logic        power_down;
  logic        dummy;
  logic [15:0] word;
  logic [3:0]  early;
  logic        trk_first;
  logic        trk_end;
  int          mismatches;
  int          checked;
  int          cycles;
  int          n_strobe;

  ////////////////////////////////////////////////////////////////////////////////
  // Device and host.
  apmc_power_mode_control u_apmc_power_mode_control (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_cs_b(cs_b), .i_sclk(sclk),
    .i_sample_data(i_sample_data), .o_serial_out_line(sdo), .o_serial_out_line_oe(sdo_oe),
    .o_analog_on(analog_on), .o_track(track), .o_sample_strobe(strobe), .o_power_down(power_down),
    .o_dummy_frame(dummy));
  apmc_host_model u_apmc_host_model (
    .i_sys_clk(i_sys_clk), .o_cs_b(cs_b), .o_sclk(sclk), .i_serial_out_line(sdo),
    .i_serial_out_line_oe(sdo_oe), .i_track(track), .i_dummy_frame(dummy), .i_analog_on(analog_on),
    .i_sample_strobe(strobe));

  // Clock at 40 MHz.
  always #12.5 i_sys_clk = ~i_sys_clk;

  // A hang is cut short well beyond the expected length of the run.
  always @(posedge i_sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles >= 10000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Status packed as power-down, analog on, output enable, dummy frame.
  task automatic chk_status(input logic [3:0] exp);
    check("status", {12'h000, exp}, {12'h000, power_down, analog_on, sdo_oe, dummy});
  endtask

  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset();
    chk_status(4'h4);
    check("track", 16'h0001, {15'h0000, track});
    check("strobe", 16'h0000, {15'h0000, strobe});
  endtask

  // Two full frames back to back; neither is a dummy cycle, as reset leaves the block in normal mode.
  task automatic t_full();
    logic [11:0] vals [2];
    vals = '{12'ha5c, 12'h3f1};
    foreach (vals[i])
    begin
      i_sample_data = vals[i];
      n_strobe = u_apmc_host_model.strobes;
      u_apmc_host_model.frame(16, word, early, trk_first, trk_end);
      check("word", {4'h0, vals[i]}, word);
      check("start", 16'h0009, {12'h000, early});
      check("strobes", 16'h0001, 16'(u_apmc_host_model.strobes - n_strobe));
      check("track_end", 16'h0001, {15'h0000, trk_end});
      chk_status(4'h4);
    end
  endtask

  // Early rises: glitches below two edges and aborts from the tenth edge on stay powered.
  task automatic t_abort();
    int cnt [5];
    cnt = '{0, 1, 10, 12, 15};
    i_sample_data = 12'hc3a;
    foreach (cnt[i])
    begin
      u_apmc_host_model.frame(cnt[i], word, early, trk_first, trk_end);
      check("partial", 16'h0c3a >> (16 - cnt[i]), word);
      check("track_end", {15'h0000, cnt[i] > 13}, {15'h0000, trk_end});
      chk_status(4'h4);
      check("track", 16'h0001, {15'h0000, track});
    end
  endtask

  // Entry at both window edges, a refused wake, then a wake of full or shortened length.
  task automatic t_power_down();
    int entry [2];
    int fail [2];
    int wake [2];
    entry = '{2, 9};
    fail = '{9, 1};
    wake = '{16, 10};
    foreach (entry[i])
    begin
      u_apmc_host_model.frame(entry[i], word, early, trk_first, trk_end);
      chk_status(4'h8);
      check("hold", 16'h0000, {15'h0000, track});
      u_apmc_host_model.frame(fail[i], word, early, trk_first, trk_end);
      check("wake_start", 16'h000b, {12'h000, early});
      check("wake_track", 16'h0001, {15'h0000, trk_first});
      chk_status(4'h8);
      u_apmc_host_model.frame(wake[i], word, early, trk_first, trk_end);
      chk_status(4'h4);
    end
  endtask

  // With the clock enable low a power-down frame must leave no trace.
  task automatic t_clk_en();
    n_strobe = u_apmc_host_model.strobes;
    i_clk_en = 1'b0;
    u_apmc_host_model.frame(5, word, early, trk_first, trk_end);
    i_clk_en = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk_status(4'h4);
    check("strobes", 16'h0000, 16'(u_apmc_host_model.strobes - n_strobe));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, ending with a reset taken from power-down.
  initial
  begin
    i_sys_clk = 1'b0;
    i_clk_en = 1'b1;
    i_sample_data = 12'h000;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    t_reset();
    t_full();
    t_abort();
    t_power_down();
    t_clk_en();
    u_apmc_host_model.frame(2, word, early, trk_first, trk_end);
    t_reset();
    print_verdict();
  end
endmodule
